// ### rtl/tcc_pkg.sv
// Package with register map, field layout, modes and carrier structs of the capture/compare timer.
// Functional notes
// R1 - Overflow flag sets when counter wraps FFFF to 0000 in free-running or pulse-width mode.
// R2 - Overflow interrupt pulses with flag set, only in free-running or pulse-width mode.
// R3 - Overflow flag clears on software write of zero and while count enable is zero.
// R4 - Reading the flag or the option register leaves the overflow flag unchanged.
// R5 - Software writing one to the overflow flag has no effect.
// R6 - Select bit one makes channel a capture register, zero compare; free-running mode only.
// R7 - Software changes capture selects only while count enable is zero.
// R8 - Software writes zero to option bits one to three, six and seven.
// R9 - Pulse-width mode capture only, free-running selectable, all other modes compare only.
// R10 - Channel 0 value buffered; buffer match raises ch0 interrupt, toggles enabled output 0.
// R11 - Channel 1 value buffered; buffer match raises ch1 interrupt, toggles enabled output 1.
// R12 - Counter clears on channel 0 buffer match in interval, event, trigger, one-shot, PWM.
// R13 - Free-running capture channel stores counter on its input valid edge.
// R14 - Pulse-width mode valid edge stores counter into channel and clears counter.
// R15 - Capture coinciding with read of same register returns a clean value.
// R16 - Trigger-pulse and PWM modes update buffers by batch write; others immediately.
// R17 - Capture/compare registers are 16-bit access with reset value zero.
// R18 - Counter read-back returns live counter while count enable is one.
// R19 - Counter read-back returns zero while count enable is zero, never FFFF idle value.
// R20 - Counter read-back register is read-only, 16-bit access only.
// R21 - Software avoids these registers while CPU runs from subclock or internal oscillator.
// R22 - Mode field: 000 interval through 110 pulse-width; 111 prohibited.
// R23 - Capture edges follow per-channel edge select; no edge selected means no capture.
package tcc_pkg;
    // Byte offsets on the register bus.
    localparam logic [7:0] TCC_OFS_CH0_COMPARE_BUFFER = 8'h00;
    localparam logic [7:0] TCC_OFS_CH1_COMPARE_BUFFER = 8'h04;
    localparam logic [7:0] TCC_OFS_CNT = 8'h08;
    localparam logic [7:0] TCC_OFS_OPT = 8'h0C;
    localparam logic [7:0] TCC_OFS_CTRL = 8'h10;
    // Option register fields.
    localparam int TCC_OPT_OVF = 0;
    localparam int TCC_OPT_CCS0 = 4;
    localparam int TCC_OPT_CCS1 = 5;
    // Control register fields.
    localparam int TCC_CTL_CE = 0;
    localparam int TCC_CTL_MD = 4;
    localparam int TCC_CTL_OE0 = 8;
    localparam int TCC_CTL_OE1 = 9;
    localparam int TCC_CTL_IS = 12;
    // Reset values and constants.
    localparam logic [15:0] TCC_CCR_RST = 16'h0000;
    localparam logic [15:0] TCC_CNT_IDLE = 16'hFFFF;
    localparam logic [15:0] TCC_CNT_ZERO = 16'h0000;
    localparam logic [1:0] TCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TCC_RESP_SLVERR = 2'h2;
    localparam logic [3:0] TCC_STRB_16 = 4'h3;

    // Timer modes as coded in the mode field.
    typedef enum logic [2:0] {
        TCC_MD_INTERVAL = 3'h0,
        TCC_MD_EVENT = 3'h1,
        TCC_MD_TRIGGER = 3'h2,
        TCC_MD_ONESHOT = 3'h3,
        TCC_MD_PWM = 3'h4,
        TCC_MD_FREERUN = 3'h5,
        TCC_MD_PULSEW = 3'h6,
        TCC_MD_PROHIB = 3'h7
    } tcc_mode_t;

    // Edge selection per capture input.
    typedef enum logic [1:0] {
        TCC_EDGE_NONE = 2'h0,
        TCC_EDGE_RISE = 2'h1,
        TCC_EDGE_FALL = 2'h2,
        TCC_EDGE_BOTH = 2'h3
    } tcc_edge_t;

    // Write-side bus state machine, Gray coded along idle, response.
    typedef enum logic [1:0] {
        TCC_WS_IDLE = 2'b00,
        TCC_WS_RESP = 2'b01
    } tcc_wstate_t;

    // AXI4-Lite request from the master.
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } tcc_axi_req_t;

    // AXI4-Lite answer from the slave.
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcc_axi_rsp_t;

    // Timer pins and interrupt pulses.
    typedef struct packed {
        logic timer_output0;
        logic timer_output1;
        logic ch0_match_irq;
        logic ch1_match_irq;
        logic overflow_irq;
    } tcc_pins_t;
endpackage

// ### rtl/tcc_timer_unit.sv
// Capture/compare timer core with AXI4-Lite register slave.
`timescale 1ns/1ps
module tcc_timer_unit #(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Count clock enable from the prescaler.
    input wire logic count_tick,
    // Batch write trigger for trigger-pulse and PWM modes.
    input wire logic batch_load,
    // Capture trigger inputs.
    input wire logic capture_input0,
    input wire logic capture_input1,
    // Register bus.
    input wire tcc_pkg::tcc_axi_req_t axi_req,
    output tcc_pkg::tcc_axi_rsp_t axi_rsp,
    // Pins and interrupts.
    output tcc_pkg::tcc_pins_t pins
);
    // All state in one packed struct.
    typedef struct packed {
        logic [1:0][CNT_W-1:0] ccr;
        logic [1:0][CNT_W-1:0] buf_v;
        logic [CNT_W-1:0] cnt;
        logic running;
        logic ovf;
        logic [1:0] ccs;
        logic ce;
        tcc_pkg::tcc_mode_t mode;
        logic [1:0] oe;
        logic [1:0][1:0] isel;
        logic [1:0] cap_prev;
        logic [1:0] tout;
        logic [1:0] match_irq;
        logic ovf_irq;
        tcc_pkg::tcc_wstate_t ws;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcc_state_t;

    tcc_state_t s_q;
    tcc_state_t s_d;
    logic [1:0] cap_in;
    logic [1:0] edge_hit;
    logic [1:0] is_capture;
    logic [1:0] cap_ev;
    logic [1:0] match;
    logic pulse_mode;
    logic free_mode;
    logic batch_mode;
    logic wr_fire;
    logic rd_fire;

    assign cap_in = {capture_input1, capture_input0};
    assign free_mode = (s_q.mode == tcc_pkg::TCC_MD_FREERUN);
    assign pulse_mode = (s_q.mode == tcc_pkg::TCC_MD_PULSEW);
    assign batch_mode = (s_q.mode == tcc_pkg::TCC_MD_TRIGGER) ||
        (s_q.mode == tcc_pkg::TCC_MD_PWM); // [R16]

    // Per-channel role, edge detection and match, one copy per channel.
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        always_comb
        begin
            is_capture[c] = pulse_mode || (free_mode && s_q.ccs[c]); // [R6] [R9]
            case (tcc_pkg::tcc_edge_t'(s_q.isel[c])) // [R23]
                tcc_pkg::TCC_EDGE_RISE: edge_hit[c] = cap_in[c] && !s_q.cap_prev[c];
                tcc_pkg::TCC_EDGE_FALL: edge_hit[c] = !cap_in[c] && s_q.cap_prev[c];
                tcc_pkg::TCC_EDGE_BOTH: edge_hit[c] = cap_in[c] != s_q.cap_prev[c];
                default: edge_hit[c] = 1'b0;
            endcase
            cap_ev[c] = s_q.running && is_capture[c] && edge_hit[c]; // [R13] [R14]
            match[c] = s_q.running && count_tick && !is_capture[c] &&
                (s_q.cnt == s_q.buf_v[c]); // [R10] [R11]
        end
    end

    // Bus handshakes are combinational from the state.
    assign axi_rsp.awready = (s_q.ws == tcc_pkg::TCC_WS_IDLE) && !s_q.aw_got;
    assign axi_rsp.wready = (s_q.ws == tcc_pkg::TCC_WS_IDLE) && !s_q.w_got;
    assign axi_rsp.bvalid = (s_q.ws == tcc_pkg::TCC_WS_RESP);
    assign axi_rsp.bresp = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid = s_q.rvalid;
    assign axi_rsp.rdata = s_q.rdata;
    assign axi_rsp.rresp = s_q.rresp;
    assign pins.timer_output0 = s_q.tout[0];
    assign pins.timer_output1 = s_q.tout[1];
    assign pins.ch0_match_irq = s_q.match_irq[0];
    assign pins.ch1_match_irq = s_q.match_irq[1];
    assign pins.overflow_irq = s_q.ovf_irq;

    assign wr_fire = (s_q.ws == tcc_pkg::TCC_WS_IDLE) &&
        (s_q.aw_got || axi_req.awvalid) && (s_q.w_got || axi_req.wvalid);
    assign rd_fire = axi_req.arvalid && !s_q.rvalid;

    // Next-state logic: counter, capture, compare, flags and bus slave.
    always_comb
    begin
        logic [7:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic ovf_clr;
        logic wrap;
        logic clr_cnt;
        wa = 8'h00;
        wd = 32'h0;
        ws = 4'h0;
        ovf_clr = 1'b0;
        wrap = 1'b0;
        clr_cnt = 1'b0;
        s_d = s_q;
        s_d.cap_prev = cap_in;
        s_d.match_irq = 2'b00;
        s_d.ovf_irq = 1'b0;

        // Counter: starts from idle all-ones, first tick yields zero.
        if (!s_q.ce)
        begin
            s_d.cnt = tcc_pkg::TCC_CNT_IDLE;
            s_d.running = 1'b0;
        end
        else if (!s_q.running)
        begin
            if (count_tick)
            begin
                s_d.cnt = tcc_pkg::TCC_CNT_ZERO;
                s_d.running = 1'b1;
                s_d.buf_v = s_q.ccr; // Buffers load on start in every mode.
            end
        end
        else
        begin
            clr_cnt = match[0] && !free_mode && !pulse_mode; // [R12]
            if (count_tick)
            begin
                wrap = (s_q.cnt == tcc_pkg::TCC_CNT_IDLE);
                s_d.cnt = clr_cnt ? tcc_pkg::TCC_CNT_ZERO : s_q.cnt + 1'b1;
            end
            // Batch write loads both buffers at the cycle end or on request.
            if (batch_mode && (clr_cnt || batch_load)) // [R16]
                s_d.buf_v = s_q.ccr;
            for (int c = 0; c < 2; c++)
            begin
                if (match[c])
                begin
                    s_d.match_irq[c] = 1'b1; // [R10] [R11]
                    if (s_q.oe[c])
                        s_d.tout[c] = !s_q.tout[c];
                end
                if (cap_ev[c])
                    s_d.ccr[c] = s_q.cnt; // [R13] [R14]
            end
            // Pulse-width capture restarts the count from zero.
            if (pulse_mode && |cap_ev) // [R14]
                s_d.cnt = tcc_pkg::TCC_CNT_ZERO;
        end

        // Write channel: latch address and data in any order.
        if (axi_req.awvalid && axi_rsp.awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready)
        begin
            s_d.w_got = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (wr_fire)
        begin
            wa = s_q.aw_got ? s_q.aw_addr : axi_req.awaddr;
            wd = s_q.w_got ? s_q.w_data : axi_req.wdata;
            ws = s_q.w_got ? s_q.w_strb : axi_req.wstrb;
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.ws = tcc_pkg::TCC_WS_RESP;
            s_d.bresp = tcc_pkg::TCC_RESP_OKAY;
            case ({wa[7:2], 2'b00})
                tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, tcc_pkg::TCC_OFS_CH1_COMPARE_BUFFER:
                begin
                    // Sixteen-bit access only; capture-role channels ignore writes.
                    if ((ws & tcc_pkg::TCC_STRB_16) != tcc_pkg::TCC_STRB_16) // [R17]
                        s_d.bresp = tcc_pkg::TCC_RESP_SLVERR;
                    else if (!is_capture[wa[2]])
                    begin
                        s_d.ccr[wa[2]] = wd[CNT_W-1:0];
                        if (s_q.running && !batch_mode) // [R16]
                            s_d.buf_v[wa[2]] = wd[CNT_W-1:0];
                    end
                end
                tcc_pkg::TCC_OFS_OPT:
                begin
                    if (ws[0])
                    begin
                        s_d.ccs = {wd[tcc_pkg::TCC_OPT_CCS1], wd[tcc_pkg::TCC_OPT_CCS0]};
                        ovf_clr = !wd[tcc_pkg::TCC_OPT_OVF]; // [R3] [R5]
                    end
                end
                tcc_pkg::TCC_OFS_CTRL:
                begin
                    if (ws[0])
                    begin
                        s_d.ce = wd[tcc_pkg::TCC_CTL_CE];
                        s_d.mode = tcc_pkg::tcc_mode_t'(wd[tcc_pkg::TCC_CTL_MD +: 3]); // [R22]
                    end
                    if (ws[1])
                    begin
                        s_d.oe = {wd[tcc_pkg::TCC_CTL_OE1], wd[tcc_pkg::TCC_CTL_OE0]};
                        s_d.isel = wd[tcc_pkg::TCC_CTL_IS +: 4];
                    end
                end
                default: s_d.bresp = tcc_pkg::TCC_RESP_SLVERR; // [R20]
            endcase
        end
        if ((s_q.ws == tcc_pkg::TCC_WS_RESP) && axi_req.bready)
            s_d.ws = tcc_pkg::TCC_WS_IDLE;

        // Overflow flag: set wins over a software clear; reads never touch it.
        if (!s_q.ce)
            s_d.ovf = 1'b0; // [R3]
        else if (wrap && (free_mode || pulse_mode)) // [R1]
        begin
            s_d.ovf = 1'b1;
            s_d.ovf_irq = 1'b1; // [R2]
        end
        else if (ovf_clr)
            s_d.ovf = 1'b0; // [R3]

        // Read channel; the register value is taken from the settled flops. [R4] [R15]
        if (rd_fire)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata = 32'h0;
            s_d.rresp = tcc_pkg::TCC_RESP_OKAY;
            case ({axi_req.araddr[7:2], 2'b00})
                tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER: s_d.rdata[CNT_W-1:0] = s_q.ccr[0];
                tcc_pkg::TCC_OFS_CH1_COMPARE_BUFFER: s_d.rdata[CNT_W-1:0] = s_q.ccr[1];
                tcc_pkg::TCC_OFS_CNT:
                    s_d.rdata[CNT_W-1:0] = s_q.running ? s_q.cnt
                        : tcc_pkg::TCC_CNT_ZERO; // [R18] [R19]
                tcc_pkg::TCC_OFS_OPT:
                begin
                    s_d.rdata[tcc_pkg::TCC_OPT_OVF] = s_q.ovf;
                    s_d.rdata[tcc_pkg::TCC_OPT_CCS0] = s_q.ccs[0];
                    s_d.rdata[tcc_pkg::TCC_OPT_CCS1] = s_q.ccs[1];
                end
                tcc_pkg::TCC_OFS_CTRL:
                begin
                    s_d.rdata[tcc_pkg::TCC_CTL_CE] = s_q.ce;
                    s_d.rdata[tcc_pkg::TCC_CTL_MD +: 3] = s_q.mode;
                    s_d.rdata[tcc_pkg::TCC_CTL_OE0] = s_q.oe[0];
                    s_d.rdata[tcc_pkg::TCC_CTL_OE1] = s_q.oe[1];
                    s_d.rdata[tcc_pkg::TCC_CTL_IS +: 4] = s_q.isel;
                end
                default: s_d.rresp = tcc_pkg::TCC_RESP_SLVERR;
            endcase
        end
        else if (s_q.rvalid && axi_req.rready)
            s_d.rvalid = 1'b0;
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.ccr <= {tcc_pkg::TCC_CCR_RST, tcc_pkg::TCC_CCR_RST}; // [R17]
            s_q.cnt <= tcc_pkg::TCC_CNT_IDLE;
        end
        else
            s_q <= s_d;
    end
endmodule

// ### test/tcc_assertions.sv
// Port-level concurrent checks for the capture/compare timer.
`timescale 1ns/1ps
module tcc_assertions (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Timer inputs.
    input wire logic count_tick,
    input wire logic batch_load,
    input wire logic capture_input0,
    input wire logic capture_input1,
    // Register bus and pins.
    input wire tcc_pkg::tcc_axi_req_t axi_req,
    input wire tcc_pkg::tcc_axi_rsp_t axi_rsp,
    input wire tcc_pkg::tcc_pins_t pins
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Both write halves taken at one edge, as the bench always offers them.
    wire logic wr_go = axi_req.awvalid & axi_rsp.awready & axi_req.wvalid & axi_rsp.wready;
    wire logic rd_go = axi_req.arvalid & axi_rsp.arready;

    property p_ovf_tick; pins.overflow_irq |-> $past(count_tick); endproperty
    a_ovf_tick: assert property (p_ovf_tick) else $error("overflow without tick");
    property p_ovf_pulse; pins.overflow_irq |=> !pins.overflow_irq; endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse long");
    property p_cc0_tick; pins.ch0_match_irq |-> $past(count_tick); endproperty
    a_cc0_tick: assert property (p_cc0_tick) else $error("ch0 match off tick");
    property p_cc1_tick; pins.ch1_match_irq |-> $past(count_tick); endproperty
    a_cc1_tick: assert property (p_cc1_tick) else $error("ch1 match off tick");
    property p_cnt_wr;
        wr_go && axi_req.awaddr == tcc_pkg::TCC_OFS_CNT
            |=> axi_rsp.bvalid && axi_rsp.bresp == tcc_pkg::TCC_RESP_SLVERR;
    endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("counter write accepted");
    property p_ccr_strb;
        wr_go && axi_req.awaddr == tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER && axi_req.wstrb[1:0] != 2'h3
            |=> axi_rsp.bvalid && axi_rsp.bresp == tcc_pkg::TCC_RESP_SLVERR;
    endproperty
    a_ccr_strb: assert property (p_ccr_strb) else $error("narrow write accepted");
    property p_rd_hi;
        axi_rsp.rvalid && axi_rsp.rresp == tcc_pkg::TCC_RESP_OKAY |-> axi_rsp.rdata[31:16] == 16'h0;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_rd_ans; rd_go |=> axi_rsp.rvalid && !axi_rsp.arready; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_wr_ans; wr_go |=> axi_rsp.bvalid && !axi_rsp.awready; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");

    // Main events that the bench must reach.
    c_ovf: cover property (pins.overflow_irq);
    c_cc0: cover property (pins.ch0_match_irq);
    c_cc1: cover property (pins.ch1_match_irq);
endmodule

// ### test/tcc_pin_model.sv
// Far-side model: drives the capture inputs and counts output toggles.
`timescale 1ns/1ps
module tcc_pin_model (
    // Clock.
    input wire logic clk_sys,
    // Pins seen from outside.
    input wire tcc_pkg::tcc_pins_t pins,
    output logic capture_input0,
    output logic capture_input1
);
    int n_tog0 = 0;
    int n_tog1 = 0;
    logic o0_q = 1'b0;
    logic o1_q = 1'b0;
    initial
    begin
        capture_input0 = 1'b0;
        capture_input1 = 1'b0;
    end
    // Four cycles high, four low, so the sampler never merges two edges.
    task automatic pulse(input int ch);
        capture_input0 <= (ch == 0);
        capture_input1 <= (ch == 1);
        repeat (4) @(posedge clk_sys);
        capture_input0 <= 1'b0;
        capture_input1 <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    // Toggle counts let the bench compare pin activity with match pulses.
    always @(posedge clk_sys)
    begin
        o0_q <= pins.timer_output0;
        o1_q <= pins.timer_output1;
        n_tog0 <= n_tog0 + int'(o0_q !== pins.timer_output0);
        n_tog1 <= n_tog1 + int'(o1_q !== pins.timer_output1);
    end
endmodule

// ### test/tcc_timer_unit_tb_top.sv
// Self-checking bench for the capture/compare timer.
`timescale 1ns/1ps
module tcc_timer_unit_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic count_tick = 1'b0;
    logic batch_load = 1'b0;
    logic [1:0] tmode = 2'h0;
    logic capture_input0;
    logic capture_input1;
    tcc_pkg::tcc_axi_req_t axi_req = '0;
    tcc_pkg::tcc_axi_rsp_t axi_rsp;
    tcc_pkg::tcc_pins_t pins;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_ovf = 0;
    int n_cc1 = 0;
    int cyc_n = 0;
    int last0 = -1;
    logic [31:0] rv;
    logic [1:0] rr;

    tcc_timer_unit dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .count_tick(count_tick),
        .batch_load(batch_load), .capture_input0(capture_input0),
        .capture_input1(capture_input1), .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins));
    tcc_pin_model u_pin (.clk_sys(clk_sys), .pins(pins), .capture_input0(capture_input0),
        .capture_input1(capture_input1));

    // 200 MHz clock; registers are only reached on this one bus clock.
    always #2.5 clk_sys = ~clk_sys;
    // No tick before the interval test, then every other cycle; full rate from the free-running test, before its captures, through the pulse-width test.
    always @(posedge clk_sys)
        count_tick <= (tmode == 2'h2) | ((tmode == 2'h1) & ~count_tick);
    // Event counters and the stamp of the latest channel 0 match.
    always @(posedge clk_sys)
    begin
        cyc_n <= cyc_n + 1;
        n_ovf <= n_ovf + int'(pins.overflow_irq);
        n_cc1 <= n_cc1 + int'(pins.ch1_match_irq);
        if (pins.ch0_match_irq === 1'b1)
            last0 <= cyc_n;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Answers are sampled at the falling edge; nothing moves between it and the next rise.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic ha;
        logic hw;
        logic hb;
        int n;
        n = 0;
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= s;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            ha = axi_req.awvalid & axi_rsp.awready;
            hw = axi_req.wvalid & axi_rsp.wready;
            hb = axi_rsp.bvalid;
            rr = axi_rsp.bresp;
            @(posedge clk_sys);
            axi_req.awvalid <= axi_req.awvalid & ~ha;
            axi_req.wvalid <= axi_req.wvalid & ~hw;
            n++;
        end while (hb !== 1'b1 && n < 64);
        chk({29'h0, ~hb, rr}, {30'h0, er}); // A missing answer counts as a mismatch.
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        logic ha;
        logic hr;
        int n;
        n = 0;
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            ha = axi_req.arvalid & axi_rsp.arready;
            hr = axi_rsp.rvalid;
            rv = axi_rsp.rdata;
            rr = axi_rsp.rresp;
            @(posedge clk_sys);
            axi_req.arvalid <= axi_req.arvalid & ~ha;
            n++;
        end while (hr !== 1'b1 && n < 64);
        chk({29'h0, ~hr, rr}, {30'h0, er}); // A missing answer counts as a mismatch.
    endtask
    task automatic wait0();
        int s;
        int n;
        s = last0;
        n = 0;
        while (last0 == s && n < 200)
        begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    function automatic logic [31:0] cw(input logic [2:0] md, input logic ce,
                                       input logic [1:0] oe, input logic [3:0] is);
        return {16'h0000, is, 2'h0, oe, 1'h0, md, 3'h0, ce};
    endfunction

    task automatic t_regs();
        rd(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h0);
        rd(tcc_pkg::TCC_OFS_CH1_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h0);
        rd(tcc_pkg::TCC_OFS_CNT, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h0);
        rd(8'h14, tcc_pkg::TCC_RESP_SLVERR);
        wr(tcc_pkg::TCC_OFS_CNT, 32'h55, 4'hF, tcc_pkg::TCC_RESP_SLVERR);
        wr(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, 32'h77, 4'h1, tcc_pkg::TCC_RESP_SLVERR);
        rd(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h0);
    endtask
    // Interval: cycle length, anytime rewrite, output 1 follows its matches.
    task automatic t_interval();
        int ta;
        int b0;
        int b1;
        int i1;
        wr(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, 32'h5, 4'h3, tcc_pkg::TCC_RESP_OKAY);
        wr(tcc_pkg::TCC_OFS_CH1_COMPARE_BUFFER, 32'h2, 4'h3, tcc_pkg::TCC_RESP_OKAY);
        wr(tcc_pkg::TCC_OFS_CTRL, cw(3'h0, 1'h1, 2'h2, 4'h0), 4'h3, tcc_pkg::TCC_RESP_OKAY);
        tmode <= 2'h1;
        wait0();
        b0 = u_pin.n_tog0;
        b1 = u_pin.n_tog1;
        i1 = n_cc1;
        ta = last0;
        wait0();
        chk(last0 - ta, 32'd12);
        rd(tcc_pkg::TCC_OFS_CNT, tcc_pkg::TCC_RESP_OKAY);
        chk({31'h0, rv > 32'h5}, 32'h0);
        wait0();
        ta = last0;
        wr(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, 32'h9, 4'h3, tcc_pkg::TCC_RESP_OKAY);
        wait0();
        chk(last0 - ta, 32'd20);
        chk(u_pin.n_tog0 - b0, 32'h0);
        chk(u_pin.n_tog1 - b1, n_cc1 - i1);
        chk({31'h0, n_cc1 - i1 > 1}, 32'h1);
        chk(n_ovf, 32'h0);
    endtask
    // PWM holds a rewrite back until the next cycle match.
    task automatic t_pwm();
        int ta;
        int b0;
        wr(tcc_pkg::TCC_OFS_CTRL, cw(3'h4, 1'h0, 2'h0, 4'h0), 4'h3, tcc_pkg::TCC_RESP_OKAY);
        rd(tcc_pkg::TCC_OFS_CNT, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h0);
        wr(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, 32'h3, 4'h3, tcc_pkg::TCC_RESP_OKAY);
        wr(tcc_pkg::TCC_OFS_CTRL, cw(3'h4, 1'h1, 2'h1, 4'h0), 4'h3, tcc_pkg::TCC_RESP_OKAY);
        wait0();
        wait0();
        ta = last0;
        b0 = u_pin.n_tog0;
        wr(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, 32'h9, 4'h3, tcc_pkg::TCC_RESP_OKAY);
        wait0();
        chk(last0 - ta, 32'd8);
        chk(u_pin.n_tog0 - b0, 32'h1);
        ta = last0;
        wait0();
        chk(last0 - ta, 32'd20);
        chk(n_ovf, 32'h0);
    endtask
    // Free-running: two captures eight cycles apart, then the wrap and the flag.
    task automatic t_free();
        int c0;
        int n;
        wr(tcc_pkg::TCC_OFS_CTRL, cw(3'h5, 1'h0, 2'h0, 4'h5), 4'h3, tcc_pkg::TCC_RESP_OKAY);
        wr(tcc_pkg::TCC_OFS_OPT, 32'h30, 4'h1, tcc_pkg::TCC_RESP_OKAY);
        wr(tcc_pkg::TCC_OFS_CTRL, cw(3'h5, 1'h1, 2'h0, 4'h5), 4'h3, tcc_pkg::TCC_RESP_OKAY);
        tmode <= 2'h2;
        repeat (20) @(posedge clk_sys);
        u_pin.pulse(0);
        u_pin.pulse(1);
        rd(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        c0 = rv;
        rd(tcc_pkg::TCC_OFS_CH1_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        chk(rv - c0, 32'd8);
        n = 0;
        while (n_ovf == 0 && n < 70000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(n_ovf, 32'h1);
        rd(tcc_pkg::TCC_OFS_OPT, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h31);
        rd(tcc_pkg::TCC_OFS_OPT, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h31);
        wr(tcc_pkg::TCC_OFS_OPT, 32'h30, 4'h1, tcc_pkg::TCC_RESP_OKAY);
        rd(tcc_pkg::TCC_OFS_OPT, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h30);
        wr(tcc_pkg::TCC_OFS_OPT, 32'h31, 4'h1, tcc_pkg::TCC_RESP_OKAY);
        rd(tcc_pkg::TCC_OFS_OPT, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, 32'h30);
    endtask
    // Pulse width: the edge restarts the count; channel 1 has no edge selected.
    task automatic t_pw();
        int c0;
        int c1;
        wr(tcc_pkg::TCC_OFS_CTRL, cw(3'h6, 1'h0, 2'h0, 4'h1), 4'h3, tcc_pkg::TCC_RESP_OKAY);
        rd(tcc_pkg::TCC_OFS_CH1_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        c1 = rv;
        wr(tcc_pkg::TCC_OFS_CTRL, cw(3'h6, 1'h1, 2'h0, 4'h1), 4'h3, tcc_pkg::TCC_RESP_OKAY);
        repeat (10) @(posedge clk_sys);
        u_pin.pulse(0);
        u_pin.pulse(0);
        u_pin.pulse(1);
        rd(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        chk({31'h0, rv < 32'd7 || rv > 32'd9}, 32'h0);
        c0 = rv;
        wr(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, 32'h1234, 4'h3, tcc_pkg::TCC_RESP_OKAY);
        rd(tcc_pkg::TCC_OFS_CH0_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, c0);
        rd(tcc_pkg::TCC_OFS_CH1_COMPARE_BUFFER, tcc_pkg::TCC_RESP_OKAY);
        chk(rv, c1);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // The wrap run dominates at about 66k cycles; 90k cycles keeps a hang inside budget.
    initial
    begin
        #450000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        axi_req.bready <= 1'b1;
        axi_req.rready <= 1'b1;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_interval();
        t_pwm();
        t_free();
        t_pw();
        end_of_test();
    end
endmodule

bind tcc_timer_unit tcc_assertions u_chk (.clk_sys, .sys_rst, .count_tick, .batch_load,
    .capture_input0, .capture_input1, .axi_req, .axi_rsp, .pins);
